// ===== core/slt_pkg.sv
// Constants and types for the sensor control and light timing block.
// Assumes a 25 MHz core clock and a host-driven register link clock.
// Functional notes
// RULE_01 - Writing 1 to calibration bit 0 starts offset calibration; result goes to offset.
// RULE_02 - Calibration end sets the done flag; its interrupt needs the enable.
// RULE_03 - Writing 0 to the start bit aborts a running calibration at once.
// RULE_04 - Enable bits 7 and 6 gate light and proximity saturation interrupts.
// RULE_05 - Enable bits 5 and 4 gate proximity one and zero interrupts.
// RULE_06 - Enable bit 3 gates the light threshold interrupt.
// RULE_07 - Enable bit 1 gates calibration interrupts; bit 2 is reserved, zero.
// RULE_08 - Enable bit 0 gates system interrupts; all enable bits reset to 0.
// RULE_09 - Control bit 2 starts a manual autozero of the light engines.
// RULE_10 - Host clears the light enable before asking for a manual autozero.
// RULE_11 - Control bit 0 clears the sleep flag and resumes measurement.
// RULE_12 - The three identification registers are read-only; writes change nothing.
// RULE_13 - Integration time in ms is (steps+1) times (step size+1) over 360.
// RULE_14 - Full-scale count is (steps+1) times (step size+1).
// RULE_15 - Step size resets to 999, a 2.78 ms step.
// RULE_16 - Host should use step size 599 and step count 29 for 50 ms.
// RULE_17 - With wait enabled, each light sample starts at the wait interval.
// RULE_18 - A wait shorter than the integration sets the light trigger fault.
// RULE_19 - Host programs a wait long enough for all enabled functions.
// RULE_20 - Step count n gives n+1 steps, 1 to 256, reset 0x00.
// RULE_21 - Enable bit 1 turns the light function on or off.
// RULE_22 - Enable bit 3 turns the wait timer on or off.
// RULE_23 - Wait period is 2.78 ms times the wait value plus one.
// RULE_24 - Interrupt output is high while any enabled source is pending.
package slt_pkg;
  localparam logic [7:0] A_ENABLE = 8'h80;
  localparam logic [7:0] A_STEPS  = 8'h81;
  localparam logic [7:0] A_WAIT   = 8'h83;
  localparam logic [7:0] A_AUX_IDENT  = 8'h90;
  localparam logic [7:0] A_REV_IDENT  = 8'h91;
  localparam logic [7:0] A_DEVID  = 8'h92;
  localparam logic [7:0] A_OFS_LO = 8'hc7;
  localparam logic [7:0] A_OFS_HI = 8'hc8;
  localparam logic [7:0] A_SZ_LO  = 8'hca;
  localparam logic [7:0] A_SZ_HI  = 8'hcb;
  localparam logic [7:0] A_CAL    = 8'hea;
  localparam logic [7:0] A_INTEN  = 8'hf9;
  localparam logic [7:0] A_CTRL   = 8'hfa;
  localparam int B_PON  = 0;
  localparam int B_LEN  = 1;
  localparam int B_PEN  = 2;
  localparam int B_WEN  = 3;
  localparam int B_AZ   = 2;
  localparam int B_SREL = 0;
  localparam logic [7:0]  RST_STEPS = 8'h00;
  localparam logic [15:0] RST_SIZE  = 16'h03e7;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [7:0]  INTEN_USED = 8'hfb;
  // Step tick of 2.78 us; least time, so round up
  localparam int TICK_NS  = 2780;
  localparam int CLK_MHZ  = 25;
  localparam int TICK_CYC = (TICK_NS * CLK_MHZ + 999) / 1000;
  // Wait unit of 2.78 ms is 1000 ticks, held as value minus one
  localparam logic [15:0] WAIT_UNIT_M1 = 16'h03e7;
  localparam int CAL_CYC  = 64;
  localparam int MS_DIV   = 360;
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } slt_req_t;
  typedef enum logic [1:0] {
    TM_IDLE  = 2'b00,
    TM_INTEG = 2'b01,
    TM_WAIT  = 2'b10
  } slt_tm_t;
  typedef enum logic {
    CAL_IDLE = 1'b0,
    CAL_RUN  = 1'b1
  } slt_cal_t;
endpackage

// ===== core/slt_core.sv
// Register file, calibration, interrupt mask and light timing.
// Host link is a word-level port on its own clock; front end on clk_i.
`timescale 1ns/1ps
module slt_core
  import slt_pkg::*;
#(
  parameter logic [7:0] AUX_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] REV_ID = 8'h01, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h3c  // Arbitrary value
)(
  // Core clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Host register link
  input  wire logic        link_clk_i,
  input  wire logic        link_req_i,
  input  wire slt_req_t    link_cmd_i,
  output logic             link_busy_o,
  output logic             link_ack_o,
  output logic [7:0]       link_rdata_o,
  // Front-end pending sources, sleep entry and proximity sample
  input  wire logic        light_sat_i,
  input  wire logic        prox_sat_i,
  input  wire logic        prox_one_i,
  input  wire logic        prox_zero_i,
  input  wire logic        light_thresh_i,
  input  wire logic        system_i,
  input  wire logic        sleep_enter_i,
  input  wire logic [15:0] prox_sample_i,
  // Status and actions
  output logic             irq_o,
  output logic             cal_busy_o,
  output logic             cal_done_flag_o,
  output logic             light_manual_zeroing_o,
  output logic             sleep_after_irq_flag_o,
  output logic             sample_start_o,
  output logic             integ_active_o,
  output logic [23:0]      full_scale_o,
  output logic [15:0]      integ_ms_o,
  output logic             light_trigger_fault_o
);

  function automatic logic [23:0] prod_inc(input logic [15:0] a,
                                           input logic [7:0] b);
    logic [24:0] p;
    p = ({9'h0, a} + 25'h1) * ({17'h0, b} + 25'h1);
    return p[23:0];
  endfunction

  // Link domain: reset crossing and request capture
  logic       lrst1_q;
  logic       lrst2_q;
  logic       lrst_q;
  logic       req_tgl_q;
  slt_req_t   cmd_q;
  logic [2:0] lack_q;

  always_ff @(posedge link_clk_i)
  begin
    // Three stages; reset leaves the link domain on the third edge
    lrst1_q <= reset_i;
    lrst2_q <= lrst1_q;
    lrst_q  <= lrst2_q;
  end

  always_ff @(posedge link_clk_i)
  begin
    if (lrst_q)
    begin
      req_tgl_q   <= 1'b0;
      cmd_q       <= '0;
      link_busy_o <= 1'b0;
    end
    else if (link_req_i && !link_busy_o)
    begin
      // Command held stable until the core answers
      cmd_q       <= link_cmd_i;
      req_tgl_q   <= ~req_tgl_q;
      link_busy_o <= 1'b1;
    end
    else if (lack_q[1] ^ lack_q[2])
      link_busy_o <= 1'b0;
  end

  // Core domain: request sync and answer toggle
  logic [2:0] creq_q;
  logic       ack_tgl_q;
  logic [7:0] rdata_q;
  logic       acc;
  logic       wr;
  logic [7:0] wa;
  logic [7:0] wd;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      creq_q <= 3'h0;
    else
      creq_q <= {creq_q[1:0], req_tgl_q};
  end

  assign acc = creq_q[1] ^ creq_q[2];
  assign wr  = acc && cmd_q.we;
  assign wa  = cmd_q.addr;
  assign wd  = cmd_q.data;

  always_ff @(posedge link_clk_i)
  begin
    if (lrst_q)
    begin
      lack_q       <= 3'h0;
      link_ack_o   <= 1'b0;
      link_rdata_o <= 8'h00;
    end
    else
    begin
      lack_q     <= {lack_q[1:0], ack_tgl_q};
      link_ack_o <= lack_q[1] ^ lack_q[2];
      if (lack_q[1] ^ lack_q[2])
        link_rdata_o <= rdata_q;
    end
  end

  // Configuration registers
  logic [7:0]  enable_q;
  logic [7:0]  steps_q;
  logic [15:0] size_q;
  logic [7:0]  wait_q;
  logic [7:0]  inten_q;
  logic [15:0] ofs_q;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      enable_q <= RST_BYTE;
      steps_q  <= RST_STEPS;                   // [RULE_20]
      size_q   <= RST_SIZE;                    // [RULE_15]
      wait_q   <= RST_BYTE;
      inten_q  <= RST_BYTE;                    // [RULE_08]
    end
    else if (wr)
    begin
      unique case (wa)
        A_ENABLE:
        begin
          enable_q <= {4'h0, wd[3:0]};         // [RULE_21] [RULE_22]
          // Power off also drops the function enables
          if (!wd[B_PON])
          begin
            enable_q[B_LEN] <= 1'b0;
            enable_q[B_PEN] <= 1'b0;
          end
        end
        A_STEPS: steps_q <= wd;
        A_WAIT:  wait_q <= wd;
        A_SZ_LO: size_q[7:0] <= wd;
        A_SZ_HI: size_q[15:8] <= wd;
        A_INTEN: inten_q <= wd & INTEN_USED;   // [RULE_07]
        default: ;                             // [RULE_12]
      endcase
    end
  end

  // Calibration
  slt_cal_t    cal_q;
  logic [7:0]  cal_cnt_q;
  logic        cal_end;

  assign cal_end = (cal_q == CAL_RUN) && (cal_cnt_q == 8'(CAL_CYC - 1));

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cal_q           <= CAL_IDLE;
      cal_cnt_q       <= 8'h00;
      cal_done_flag_o <= 1'b0;
      ofs_q           <= 16'h0000;
    end
    else
    begin
      cal_cnt_q <= (cal_q == CAL_RUN) ? cal_cnt_q + 8'h01 : 8'h00;
      if (wr && wa == A_CAL && wd[0])
      begin
        cal_q           <= CAL_RUN;            // [RULE_01]
        cal_cnt_q       <= 8'h00;
        cal_done_flag_o <= 1'b0;
      end
      else if (wr && wa == A_CAL && cal_q == CAL_RUN)
        cal_q <= CAL_IDLE;                     // [RULE_03]
      else if (cal_end)
      begin
        cal_q           <= CAL_IDLE;
        cal_done_flag_o <= 1'b1;               // [RULE_02]
        ofs_q           <= prox_sample_i;      // [RULE_01]
      end
      else if (wr && wa == A_OFS_LO)
        ofs_q[7:0] <= wd;
      else if (wr && wa == A_OFS_HI)
        ofs_q[15:8] <= wd;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cal_busy_o <= 1'b0;
    else
      cal_busy_o <= (cal_q == CAL_RUN);
  end

  // Control actions; control reads back zero as its bits are actions
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      light_manual_zeroing_o <= 1'b0;
      sleep_after_irq_flag_o <= 1'b0;
    end
    else
    begin
      // Host must have cleared the light enable for this to work
      light_manual_zeroing_o <= wr && wa == A_CTRL && wd[B_AZ];  // [RULE_09] [RULE_10]
      // Hardware entry wins over a release in the same cycle
      if (sleep_enter_i)
        sleep_after_irq_flag_o <= 1'b1;
      else if (wr && wa == A_CTRL && wd[B_SREL])
        sleep_after_irq_flag_o <= 1'b0;        // [RULE_11]
    end
  end

  // Interrupt gating
  logic [7:0] pend;
  assign pend = {light_sat_i, prox_sat_i, prox_one_i, prox_zero_i,
                 light_thresh_i, 1'b0, cal_done_flag_o, system_i};

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(pend & inten_q);  // [RULE_04] [RULE_05] [RULE_06] [RULE_07] [RULE_24]
  end

  // Read mux
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_q   <= 8'h00;
      ack_tgl_q <= 1'b0;
    end
    else if (acc)
    begin
      ack_tgl_q <= ~ack_tgl_q;
      unique case (wa)
        A_ENABLE: rdata_q <= enable_q;
        A_STEPS:  rdata_q <= steps_q;
        A_WAIT:   rdata_q <= wait_q;
        A_AUX_IDENT:  rdata_q <= AUX_ID;           // [RULE_12]
        A_REV_IDENT:  rdata_q <= REV_ID;
        A_DEVID:  rdata_q <= DEV_ID;
        A_OFS_LO: rdata_q <= ofs_q[7:0];
        A_OFS_HI: rdata_q <= ofs_q[15:8];
        A_SZ_LO:  rdata_q <= size_q[7:0];
        A_SZ_HI:  rdata_q <= size_q[15:8];
        A_CAL:    rdata_q <= {7'h0, cal_q == CAL_RUN};
        A_INTEN:  rdata_q <= inten_q;
        default:  rdata_q <= 8'h00;
      endcase
    end
  end

  // Light timing
  logic [23:0] fs;
  logic [23:0] wait_ticks;
  logic        light_on;
  logic        wen;
  logic [7:0]  tick_cnt_q;
  logic        tick;
  slt_tm_t     tm_q;
  logic [23:0] integ_cnt_q;
  logic [23:0] wait_cnt_q;
  logic        integ_last;
  logic        wait_over;

  assign fs         = prod_inc(size_q, steps_q);          // [RULE_14]
  assign wait_ticks = prod_inc(WAIT_UNIT_M1, wait_q);     // [RULE_23]
  assign light_on   = enable_q[B_PON] && enable_q[B_LEN];
  assign wen        = enable_q[B_WEN];
  assign tick       = tick_cnt_q == 8'(TICK_CYC - 1);
  assign integ_last = tick && (integ_cnt_q == fs - 24'h1);
  assign wait_over  = wait_cnt_q >= wait_ticks - 24'h1;

  always_ff @(posedge clk_i)
  begin
    if (reset_i || !enable_q[B_PON] || tick)
      tick_cnt_q <= 8'h00;
    else
      tick_cnt_q <= tick_cnt_q + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tm_q           <= TM_IDLE;
      integ_cnt_q    <= 24'h0;
      wait_cnt_q     <= 24'h0;
      sample_start_o <= 1'b0;
    end
    else
    begin
      sample_start_o <= 1'b0;
      if (tick)
      begin
        integ_cnt_q <= integ_cnt_q + 24'h1;
        wait_cnt_q  <= wait_cnt_q + 24'h1;
      end
      unique case (tm_q)
        TM_IDLE:
          if (light_on)
          begin
            tm_q           <= TM_INTEG;
            integ_cnt_q    <= 24'h0;
            wait_cnt_q     <= 24'h0;
            sample_start_o <= 1'b1;
          end
        TM_INTEG:
          if (!light_on)
            tm_q <= TM_IDLE;
          else if (integ_last)
          begin
            integ_cnt_q <= 24'h0;
            if (wen && !(wait_over && tick))
              tm_q <= TM_WAIT;
            else
            begin
              // Free running, or wait already elapsed
              wait_cnt_q     <= 24'h0;
              sample_start_o <= 1'b1;
            end
          end
        TM_WAIT:
          if (!light_on)
            tm_q <= TM_IDLE;
          else if (!wen || (tick && wait_over))
          begin
            tm_q           <= TM_INTEG;        // [RULE_17]
            integ_cnt_q    <= 24'h0;
            wait_cnt_q     <= 24'h0;
            sample_start_o <= 1'b1;
          end
        default: tm_q <= TM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      integ_active_o        <= 1'b0;
      full_scale_o          <= 24'h0;
      integ_ms_o            <= 16'h0;
      light_trigger_fault_o <= 1'b0;
    end
    else
    begin
      integ_active_o <= (tm_q == TM_INTEG);
      full_scale_o   <= fs;                           // [RULE_14]
      integ_ms_o     <= 16'(fs / 24'(MS_DIV));        // [RULE_13]
      // Only the integration is known here; host covers the rest
      light_trigger_fault_o <= light_on && wen && (wait_ticks < fs);  // [RULE_18] [RULE_19]
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_cal_go;
    wr && wa == A_CAL && wd[0];
  endsequence

  sequence s_cal_full;
    (cal_q == CAL_RUN) [*8];
  endsequence

  chk_cal_launch: assert property (s_cal_go |=> cal_q == CAL_RUN && !cal_done_flag_o) // [RULE_01]
    else $error("calibration did not start");

  chk_cal_finish: assert property (cal_end |=> cal_done_flag_o && cal_q == CAL_IDLE
                                   && ofs_q == $past(prox_sample_i)) // [RULE_02]
    else $error("calibration end not recorded");

  chk_cal_abort: assert property (wr && wa == A_CAL && !wd[0] && cal_q == CAL_RUN
                                  |=> cal_q == CAL_IDLE && !cal_done_flag_o) // [RULE_03]
    else $error("calibration abort ignored");

  chk_cal_length: assert property (s_cal_go ##1 s_cal_full |-> !cal_done_flag_o) // [RULE_02]
    else $error("calibration ended early");

  chk_irq_gate: assert property (irq_o == $past(|(pend & inten_q), 1)) // [RULE_24]
    else $error("interrupt output not gated by mask");

  chk_mask_rsvd: assert property (!inten_q[2] && (!$past(reset_i) || inten_q == 8'h00)) // [RULE_07]
    else $error("mask reserved or reset bit wrong");

  chk_step_reset: assert property ($past(reset_i) |-> size_q == RST_SIZE
                                   && steps_q == RST_STEPS) // [RULE_15]
    else $error("step reset values wrong");

  chk_az_pulse: assert property (wr && wa == A_CTRL && wd[B_AZ]
                                 |=> light_manual_zeroing_o ##1 !light_manual_zeroing_o) // [RULE_09]
    else $error("autozero pulse wrong");

  chk_sleep_clear: assert property (wr && wa == A_CTRL && wd[B_SREL] && !sleep_enter_i
                                    |=> !sleep_after_irq_flag_o) // [RULE_11]
    else $error("sleep flag not released");

  chk_trig_fault: assert property (light_on && wen && wait_ticks < fs && $stable(fs)
                                   |=> light_trigger_fault_o) // [RULE_18]
    else $error("trigger fault not raised");

  chk_full_scale: assert property (##1 $stable(fs) |-> full_scale_o
                                   == ({8'h0, steps_q} + 24'h1) * (size_q + 24'h1)) // [RULE_14]
    else $error("full scale mismatch");

endmodule

// ===== sim/slt_host.sv
// Host model driving the word-level register link, one transfer at a time.
// Assumes the link clock runs freely and the core answers with busy/ack.
`timescale 1ns/1ps
module slt_host
  import slt_pkg::*;
(
  // Link from the core
  input  wire logic       link_clk_i,
  input  wire logic       link_busy_i,
  input  wire logic       link_ack_i,
  input  wire logic [7:0] link_rdata_i,
  // Link to the core
  output logic            link_req_o,
  output slt_req_t        link_cmd_o
);
  initial
  begin
    link_req_o = 1'b0;
    link_cmd_o = '0;
  end
  // Taken on the first edge after the host sees busy low
  task automatic xfer(input logic we, input logic [7:0] addr, input logic [7:0] data,
                      output logic [7:0] rdata);
    int n;
    rdata = 8'hxx;
    @(posedge link_clk_i);
    #2;
    // Busy only moves on edges, so this is what the next edge sees
    while (link_busy_i !== 1'b0)
    begin
      @(posedge link_clk_i);
      #2;
    end
    link_req_o = 1'b1;
    link_cmd_o = '{we: we, addr: addr, data: data};
    @(posedge link_clk_i);
    #2;
    link_req_o = 1'b0;
    // Released command inverted so stale bits never look valid
    link_cmd_o = slt_req_t'(~link_cmd_o);
    for (n = 0; n < 40; n++)
    begin
      if (link_ack_i === 1'b1)
        break;
      @(posedge link_clk_i);
      #2;
    end
    if (link_ack_i === 1'b1)
      rdata = link_rdata_i;
  endtask
endmodule

// ===== sim/test_sensor_control_and_light_timing.sv
// Self-checking bench for the sensor control and light timing core.
// Assumes the host model in slt_host.sv drives the register link.
`timescale 1ns/1ps
module test_sensor_control_and_light_timing
  import slt_pkg::*;
;
  localparam logic [7:0] AUX_V = 8'h6b; // Arbitrary value
  localparam logic [7:0] REV_V = 8'h07; // Arbitrary value
  localparam logic [7:0] DEV_V = 8'hd3; // Arbitrary value
  logic        clk_i = 1'b0;
  logic        link_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        link_req_i;
  slt_req_t    link_cmd_i;
  logic        link_busy_o, link_ack_o, sleep_enter_i = 1'b0;
  logic [7:0]  link_rdata_o;
  logic [5:0]  src = 6'h00;
  logic [15:0] prox_sample_i = 16'hbeef;
  logic        irq_o, cal_busy_o, cal_done_flag_o, az_o, sleep_o, ss_o, fault_o, act_o;
  logic [23:0] full_scale_o;
  logic [15:0] integ_ms_o;
  int          bad_count = 0, comparisons = 0, cyc = 0, n_az = 0, n_ss = 0;
  int          t_last = 0, t_prev = 0;

  slt_core #(.AUX_ID(AUX_V), .REV_ID(REV_V), .DEV_ID(DEV_V)) i_slt_core (
    .clk_i(clk_i), .reset_i(reset_i), .link_clk_i(link_clk_i),
    .link_req_i(link_req_i), .link_cmd_i(link_cmd_i), .link_busy_o(link_busy_o),
    .link_ack_o(link_ack_o), .link_rdata_o(link_rdata_o),
    .light_sat_i(src[5]), .prox_sat_i(src[4]), .prox_one_i(src[3]),
    .prox_zero_i(src[2]), .light_thresh_i(src[1]), .system_i(src[0]),
    .sleep_enter_i(sleep_enter_i), .prox_sample_i(prox_sample_i), .irq_o(irq_o),
    .cal_busy_o(cal_busy_o), .cal_done_flag_o(cal_done_flag_o),
    .light_manual_zeroing_o(az_o), .sleep_after_irq_flag_o(sleep_o),
    .sample_start_o(ss_o), .integ_active_o(act_o), .full_scale_o(full_scale_o),
    .integ_ms_o(integ_ms_o), .light_trigger_fault_o(fault_o));
  slt_host i_slt_host (
    .link_clk_i(link_clk_i), .link_busy_i(link_busy_o), .link_ack_i(link_ack_o),
    .link_rdata_i(link_rdata_o), .link_req_o(link_req_i), .link_cmd_o(link_cmd_i));

  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    #5;
    forever #32 link_clk_i = ~link_clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (az_o === 1'b1)
      n_az++;
    if (ss_o === 1'b1)
    begin
      t_prev = t_last;
      t_last = cyc;
      n_ss++;
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_slt_host.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    i_slt_host.xfer(1'b0, a, 8'h00, r);
    chk($sformatf("reg %0h", a), {16'h0, exp}, {16'h0, r});
  endtask

  task automatic t_reset_values();
    rd(A_STEPS, 8'h00);
    rd(A_INTEN, 8'h00);
    rd(A_SZ_LO, 8'he7);
    rd(A_SZ_HI, 8'h03);
    rd(A_CAL, 8'h00);
    chk("full_scale", 24'd1000, full_scale_o);
    chk("integ_ms", 24'd2, {8'h0, integ_ms_o});
  endtask
  task automatic t_ident();
    logic [7:0] ids [3];
    ids = '{AUX_V, REV_V, DEV_V};
    for (int i = 0; i < 3; i++)
    begin
      wr(A_AUX_IDENT + 8'(i), ~ids[i]);
      rd(A_AUX_IDENT + 8'(i), ids[i]);
    end
    wr(8'h85, 8'ha5);
    rd(8'h85, 8'h00);
  endtask
  task automatic t_irq_mask();
    int bp [6];
    bp = '{7, 6, 5, 4, 3, 0};
    wr(A_INTEN, 8'hff);
    rd(A_INTEN, 8'hfb);
    for (int k = 0; k < 6; k++)
    begin
      tick(1);
      src = 6'h20 >> k;
      wr(A_INTEN, 8'hfb & ~(8'h01 << bp[k]));
      tick(4);
      chk("irq masked", 24'd0, {23'h0, irq_o});
      wr(A_INTEN, 8'h01 << bp[k]);
      tick(4);
      chk("irq enabled", 24'd1, {23'h0, irq_o});
      src = 6'h00;
      tick(4);
      chk("irq idle", 24'd0, {23'h0, irq_o});
    end
  endtask
  task automatic t_calibration_start();
    wr(A_INTEN, 8'h02);
    wr(A_CAL, 8'h01);
    chk("cal busy", 24'd1, {23'h0, cal_busy_o});
    for (int i = 0; i < 200 && cal_done_flag_o !== 1'b1; i++)
      tick(1);
    tick(3);
    chk("cal done", 24'd1, {23'h0, cal_done_flag_o});
    chk("cal irq", 24'd1, {23'h0, irq_o});
    rd(A_OFS_LO, 8'hef);
    rd(A_OFS_HI, 8'hbe);
    wr(A_INTEN, 8'h00);
    tick(4);
    chk("cal irq off", 24'd0, {23'h0, irq_o});
    wr(A_CAL, 8'h01);
    wr(A_CAL, 8'h00);
    tick(3);
    chk("abort busy", 24'd0, {23'h0, cal_busy_o});
    tick(100);
    chk("abort done", 24'd0, {23'h0, cal_done_flag_o});
  endtask
  task automatic t_control();
    int n;
    wr(A_ENABLE, 8'h01);
    n = n_az;
    wr(A_CTRL, 8'h01 << B_AZ);
    tick(4);
    chk("autozero", 24'(n + 1), 24'(n_az));
    rd(A_CTRL, 8'h00);
    tick(1);
    sleep_enter_i = 1'b1;
    tick(1);
    sleep_enter_i = 1'b0;
    tick(3);
    chk("sleep set", 24'd1, {23'h0, sleep_o});
    wr(A_CTRL, 8'h01 << B_SREL);
    tick(4);
    chk("sleep clear", 24'd0, {23'h0, sleep_o});
  endtask
  task automatic t_timing();
    int n;
    wr(A_STEPS, 8'd29);
    wr(A_SZ_LO, 8'h57);
    wr(A_SZ_HI, 8'h02);
    tick(4);
    chk("fs 50ms", 24'd18000, full_scale_o);
    chk("ms 50ms", 24'd50, {8'h0, integ_ms_o});
    wr(A_STEPS, 8'hff);
    wr(A_SZ_LO, 8'h00);
    wr(A_SZ_HI, 8'h00);
    tick(4);
    chk("fs max steps", 24'd256, full_scale_o);
    wr(A_STEPS, 8'h01);
    wr(A_ENABLE, 8'h03);
    tick(500);
    n = t_last - t_prev;
    chk("sample pace", 24'd1, {23'h0, n >= 2 * TICK_CYC && n <= 2 * TICK_CYC + 2});
    chk("integ on", 24'd1, {23'h0, act_o});
    wr(A_WAIT, 8'h00);
    wr(A_ENABLE, 8'h0b);
    n = n_ss;
    tick(1000);
    chk("wait pace", 24'd1, {23'h0, n_ss - n <= 1});
    chk("no fault", 24'd0, {23'h0, fault_o});
    wr(A_SZ_LO, 8'h0f);
    wr(A_STEPS, 8'hff);
    tick(4);
    chk("fault set", 24'd1, {23'h0, fault_o});
    wr(A_ENABLE, 8'h03);
    tick(4);
    chk("fault wait off", 24'd0, {23'h0, fault_o});
    wr(A_ENABLE, 8'h01);
    tick(4);
    n = n_ss;
    tick(500);
    chk("light off", 24'(n), 24'(n_ss));
    chk("integ off", 24'd0, {23'h0, act_o});
  endtask

  initial
  begin
    repeat (6) @(posedge clk_i);
    #2;
    reset_i = 1'b0;
    repeat (4) @(posedge link_clk_i);
    t_reset_values();
    t_ident();
    t_irq_mask();
    t_calibration_start();
    t_control();
    t_timing();
    give_verdict();
  end
  initial
  begin
    #(40 * 60000);
    bad_count++;
    give_verdict();
  end
endmodule
